// ---- logic/port_pair_defs.vh ----
// Function
// - each low-byte pin chooses input or output by its own direction bit
// - reset clears low-byte output latch and direction, all pins input
// - external memory access makes low byte the data bus, clearing direction
// - reset clears high-byte output latch and direction register
// - boot pins set high-byte function bits at reset release; 01 gives bus
// - high-byte direction and function decode together per pin
// - data register reads pin levels; writes update the output latch
`ifndef PORT_PAIR_DEFS_VH
`define PORT_PAIR_DEFS_VH

// ==========================================================
// register indices (byte address = index * 4)
`define IDX_LOW_DATA      4'h0
`define IDX_HIGH_DATA     4'h1
`define IDX_LOW_DIR       4'h2
`define IDX_HIGH_DIR      4'h4
`define IDX_HIGH_FUNC     4'h5
`define IDX_STATUS        4'h6

// ==========================================================
// reset values and boot patterns
`define PORT_RESET        8'h00
`define BOOT_BUS_PATTERN  2'b01

// ==========================================================
// axi responses
`define RESP_OKAY         2'b00
`define RESP_SLVERR       2'b10

`endif

// ---- logic/byte_pin_port.v ----
`timescale 1ns/10ps
`include "port_pair_defs.vh"

// one 8-bit port: output latch, direction, function and pin muxing
module byte_pin_port #(
    parameter WIDTH     = 8,
    parameter HAS_FUNC  = 1
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    // software side
    input  wire             latch_we,
    input  wire             dir_we,
    input  wire             func_we,
    input  wire [WIDTH-1:0] wdata,
    input  wire             func_load,
    input  wire [WIDTH-1:0] func_load_val,
    input  wire             dir_clear,
    // memory bus side
    input  wire             bus_active,
    input  wire             bus_write,
    input  wire [WIDTH-1:0] bus_wdata,
    // pins
    input  wire [WIDTH-1:0] pin_in,
    output reg  [WIDTH-1:0] pin_out,
    output wire [WIDTH-1:0] pin_oe_n,
    // state
    output reg  [WIDTH-1:0] pin_level,
    output reg  [WIDTH-1:0] dir,
    output reg  [WIDTH-1:0] func
);
    reg [WIDTH-1:0] latch;
    wire [WIDTH-1:0] bus_sel;
    wire [WIDTH-1:0] drive;

    // ==========================================================
    // registers
    always @(posedge clk) begin
        if (!rst_n) begin
            latch <= {WIDTH{1'b0}};
            dir   <= {WIDTH{1'b0}};
            func  <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (latch_we)
                latch <= wdata;
            if (dir_clear)
                dir <= {WIDTH{1'b0}};
            else if (dir_we)
                dir <= wdata;
            if (func_load)
                func <= func_load_val;
            else if (func_we && HAS_FUNC != 0)
                func <= wdata;
        end
    end

    // pin levels sampled so reads see the outside world
    always @(posedge clk) begin
        if (!rst_n)
            pin_level <= {WIDTH{1'b0}};
        else if (ce)
            pin_level <= pin_in;
    end

    // ==========================================================
    // per-pin decode: func with dir clear selects bus (no func: bus_active), else dir picks in/out
    assign bus_sel = (HAS_FUNC != 0) ? (func & ~dir) : {WIDTH{bus_active}};
    assign drive   = (bus_sel & {WIDTH{bus_active & bus_write}})
                   | (~bus_sel & dir);
    assign pin_oe_n = ~drive;

    // registered mux keeps data outputs from flops
    // per pin, so port pins beside bus pins keep showing their latch
    always @(posedge clk) begin
        if (!rst_n)
            pin_out <= {WIDTH{1'b0}};
        else if (ce)
            pin_out <= (bus_sel & bus_wdata) | (~bus_sel & latch);
    end
endmodule

// ---- logic/data_bus_port_pair.v ----
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "port_pair_defs.vh"

// two 8-bit pin ports behind an axi4-lite slave
module data_bus_port_pair #(
    parameter WIDTH = 8
) (
    // clock, enable, reset
    input  wire             clk,
    input  wire             rst_n,
    input  wire             ce,
    // boot straps
    input  wire             boot_mode_pin_high,
    input  wire             boot_mode_pin_low,
    // external memory cycle
    input  wire             mem_access,
    input  wire             mem_write,
    input  wire [15:0]      mem_wdata,
    // low-byte pins
    input  wire [WIDTH-1:0] low_pin_in,
    output wire [WIDTH-1:0] low_pin_out,
    output wire [WIDTH-1:0] low_pin_oe_n,
    // high-byte pins
    input  wire [WIDTH-1:0] high_pin_in,
    output wire [WIDTH-1:0] high_pin_out,
    output wire [WIDTH-1:0] high_pin_oe_n,
    // axi4-lite write
    input  wire [7:0]       s_axi_awaddr,
    input  wire             s_axi_awvalid,
    output wire             s_axi_awready,
    input  wire [31:0]      s_axi_wdata,
    input  wire [3:0]       s_axi_wstrb,
    input  wire             s_axi_wvalid,
    output wire             s_axi_wready,
    output reg  [1:0]       s_axi_bresp,
    output reg              s_axi_bvalid,
    input  wire             s_axi_bready,
    // axi4-lite read
    input  wire [7:0]       s_axi_araddr,
    input  wire             s_axi_arvalid,
    output wire             s_axi_arready,
    output reg  [31:0]      s_axi_rdata,
    output reg  [1:0]       s_axi_rresp,
    output reg              s_axi_rvalid,
    input  wire             s_axi_rready
);
    // ==========================================================
    // write channel capture
    reg         aw_held;
    reg         w_held;
    reg  [7:0]  aw_addr;
    reg  [31:0] w_data;
    reg  [3:0]  w_strb;
    reg         boot_done;
    reg         rst_seen;

    wire [3:0]  wr_idx;
    wire        wr_fire;
    wire        wr_ok;
    wire        lane0;
    wire [1:0]  boot_pat;
    wire [WIDTH-1:0] low_level;
    wire [WIDTH-1:0] high_level;
    wire [WIDTH-1:0] low_dir;
    wire [WIDTH-1:0] high_dir;
    wire [WIDTH-1:0] high_func;

    // word address to register index
    function [3:0] reg_index;
        input [7:0] addr;
        begin
            reg_index = addr[5:2];
        end
    endfunction

    // known offsets only, within the mapped window
    function addr_known;
        input [7:0] addr;
        reg   [3:0] i;
        begin
            i = addr[5:2];
            addr_known = (addr[7:6] == 2'b00) &&
                ((i == `IDX_LOW_DATA) || (i == `IDX_HIGH_DATA) || (i == `IDX_LOW_DIR) ||
                 (i == `IDX_HIGH_DIR) || (i == `IDX_HIGH_FUNC) || (i == `IDX_STATUS));
        end
    endfunction

    // readies drop with ce so nothing is taken while state is frozen
    assign s_axi_awready = ~aw_held & ~s_axi_bvalid & ce;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid & ce;
    assign wr_fire = aw_held & w_held & ~s_axi_bvalid;
    assign wr_idx  = reg_index(aw_addr);
    assign wr_ok   = addr_known(aw_addr);
    assign lane0   = w_strb[0];

    // hold address and data until both are in, any order
    always @(posedge clk) begin
        if (!rst_n) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0000_0000;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // boot strap capture one cycle after reset release
    // straps are sampled by a clocked process, never by the reset itself
    assign boot_pat = {boot_mode_pin_high, boot_mode_pin_low};
    always @(posedge clk) begin
        if (!rst_n) begin
            rst_seen  <= 1'b1;
            boot_done <= 1'b0;
        end else if (ce) begin
            rst_seen  <= 1'b0;
            boot_done <= rst_seen;
        end
    end

    // ==========================================================
    // port instances
    byte_pin_port #(.WIDTH(WIDTH), .HAS_FUNC(0)) u_low (
        .clk           (clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .latch_we      (wr_fire && wr_ok && lane0 && wr_idx == `IDX_LOW_DATA),
        .dir_we        (wr_fire && wr_ok && lane0 && wr_idx == `IDX_LOW_DIR),
        .func_we       (1'b0),
        .wdata         (w_data[WIDTH-1:0]),
        .func_load     (1'b0),
        .func_load_val ({WIDTH{1'b0}}),
        .dir_clear     (mem_access),
        .bus_active    (mem_access),
        .bus_write     (mem_write),
        .bus_wdata     (mem_wdata[7:0]),
        .pin_in        (low_pin_in),
        .pin_out       (low_pin_out),
        .pin_oe_n      (low_pin_oe_n),
        .pin_level     (low_level),
        .dir           (low_dir),
        .func          ()
    );

    // 01 gives bus; 00 and 11 give input; 10 unsupported, treated as input
    byte_pin_port #(.WIDTH(WIDTH), .HAS_FUNC(1)) u_high (
        .clk           (clk),
        .rst_n         (rst_n),
        .ce            (ce),
        .latch_we      (wr_fire && wr_ok && lane0 && wr_idx == `IDX_HIGH_DATA),
        .dir_we        (wr_fire && wr_ok && lane0 && wr_idx == `IDX_HIGH_DIR),
        .func_we       (wr_fire && wr_ok && lane0 && wr_idx == `IDX_HIGH_FUNC),
        .wdata         (w_data[WIDTH-1:0]),
        .func_load     (rst_seen),
        .func_load_val ({WIDTH{boot_pat == `BOOT_BUS_PATTERN}}),
        .dir_clear     (1'b0),
        .bus_active    (mem_access),
        .bus_write     (mem_write),
        .bus_wdata     (mem_wdata[15:8]),
        .pin_in        (high_pin_in),
        .pin_out       (high_pin_out),
        .pin_oe_n      (high_pin_oe_n),
        .pin_level     (high_level),
        .dir           (high_dir),
        .func          (high_func)
    );

    // ==========================================================
    // read channel: one cycle answer, direction regs read as zero
    // (they are write-only, so software keeps its own copy)
    assign s_axi_arready = ~s_axi_rvalid & ce;
    always @(posedge clk) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                case (reg_index(s_axi_araddr))
                    `IDX_LOW_DATA:  s_axi_rdata <= {24'h000000, low_level};
                    `IDX_HIGH_DATA: s_axi_rdata <= {24'h000000, high_level};
                    `IDX_STATUS:    s_axi_rdata <= {22'h0, boot_done,
                                                    mem_access, high_func};
                    default:        s_axi_rdata <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// ---- sim/port_pair_sva.sv ----
`timescale 1ns/10ps
`include "port_pair_defs.vh"
// =====================================
// pin and bus answer checker
module port_pair_sva (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // memory cycle
    input wire logic        mem_access,
    input wire logic        mem_write,
    // pins
    input wire logic [7:0]  low_pin_in,
    input wire logic [7:0]  low_pin_oe_n,
    input wire logic [7:0]  high_pin_oe_n,
    // register bus
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // both halves of a write taken on one edge
    wire both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    chk_bus_float: assert property (mem_access && !mem_write |-> low_pin_oe_n == 8'hff)
        else $error("low port driven in bus read");
    chk_bus_drive: assert property (mem_access && mem_write |-> low_pin_oe_n == 8'h00)
        else $error("low port idle in bus write");
    // reset itself is the cause here, so no disable
    chk_reset_quiet: assert property (disable iff (1'b0)
        !rst_n ##1 !mem_access |-> (low_pin_oe_n & high_pin_oe_n) == 8'hff)
        else $error("pin driven after reset");
    chk_pin_read: assert property ($past(rst_n) && s_axi_arvalid && s_axi_arready
        && s_axi_araddr == 8'h00 && $stable(low_pin_in)
        |=> s_axi_rdata == {24'h0, $past(low_pin_in)}) else $error("low read not pins");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_write_answer: assert property (both |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing");
    chk_bad_addr: assert property (both && s_axi_awaddr == 8'h1c |-> ##2
        s_axi_bresp == `RESP_SLVERR) else $error("unmapped write not refused");
    chk_refuse_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("address taken while answer pending");
endmodule

bind data_bus_port_pair port_pair_sva u_port_pair_sva (.*);

// ---- sim/board_model.sv ----
`timescale 1ns/10ps
// =====================================
// board side of one 8-bit pin group
module board_model (
    // clock
    input wire logic       clk,
    // port side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    // board drivers
    input wire logic [7:0] ext,
    input wire logic [7:0] ext_en,
    // resolved level
    output logic [7:0]     pin_in
);
    logic [7:0] last = 8'h00;
    // floating bits flip each cycle so a stale level is never mistaken for data
    always_comb pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext)
                       | (pin_oe_n & ~ext_en & ~last);
    // remember the level for the floating case
    always @(posedge clk) last <= pin_in;
endmodule

// ---- sim/data_bus_port_pair_bench.sv ----
`timescale 1ns/10ps
`include "port_pair_defs.vh"
module data_bus_port_pair_bench;
    // =====================================
    // signals
    logic clk = 0, rst_n = 0, ce = 1, boot_mode_pin_high = 0, boot_mode_pin_low = 0;
    logic mem_access = 0, mem_write = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [15:0] mem_wdata = 16'h0;
    logic [7:0]  low_pin_in, low_pin_out, low_pin_oe_n, high_pin_in, high_pin_out, high_pin_oe_n;
    logic [7:0]  lo_ext = 8'h00, lo_en = 8'hff, hi_ext = 8'h00, hi_en = 8'hff;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    int          mismatches = 0, n_checks = 0;
    // 8 ns clock
    initial forever #4 clk = ~clk;
    data_bus_port_pair u_data_bus_port_pair (.*);
    board_model u_board_lo (.clk(clk), .pin_out(low_pin_out), .pin_oe_n(low_pin_oe_n),
                            .ext(lo_ext), .ext_en(lo_en), .pin_in(low_pin_in));
    board_model u_board_hi (.clk(clk), .pin_out(high_pin_out), .pin_oe_n(high_pin_oe_n),
                            .ext(hi_ext), .ext_en(hi_en), .pin_in(high_pin_in));
    // =====================================
    // shared tasks
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task results;
        $display("checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // write: address and data offered together, each released once taken
    task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tbv;
        @(posedge clk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_bready <= 1;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1;
        tbv = 0;
        while (!tbv) begin
            @(negedge clk);
            ta = s_axi_awvalid & s_axi_awready; tw = s_axi_wvalid & s_axi_wready;
            tbv = s_axi_bvalid; r = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tbv) s_axi_bready <= 0;
        end
    endtask
    task rdreg(input logic [7:0] a, output logic [31:0] d);
        logic ta, trv;
        @(posedge clk);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        trv = 0;
        while (!trv) begin
            @(negedge clk);
            ta = s_axi_arvalid & s_axi_arready; trv = s_axi_rvalid; d = s_axi_rdata;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 0;
            if (trv) s_axi_rready <= 0;
        end
    endtask
    task do_reset(input logic [1:0] boot);
        @(posedge clk);
        {boot_mode_pin_high, boot_mode_pin_low} <= boot; rst_n <= 0;
        repeat (5) @(posedge clk);
        rst_n <= 1;
    endtask
    // =====================================
    // scenarios
    task t_reset;
        do_reset(2'b00); lo_ext <= 8'h96;
        rdreg(8'h00, rd); chk("low pins", 32'h96, rd);
        @(negedge clk); chk("oe after reset", 8'hff, low_pin_oe_n & high_pin_oe_n);
        $display("test reset finished");
    endtask
    task t_low;
        wr(8'h00, 32'h3c, resp); wr(8'h08, 32'ha5, resp);
        lo_en <= 8'h5a; lo_ext <= 8'h0f;
        rdreg(8'h00, rd); chk("low mixed read", 32'h2e, rd);
        @(negedge clk); chk("low oe", 8'h5a, low_pin_oe_n);
        chk("low out", 8'h24, low_pin_out & 8'ha5);
        rdreg(8'h08, rd); chk("dir reads zero", 32'h0, rd);
        $display("test low port finished");
    endtask
    task t_mem;
        @(posedge clk); mem_access <= 1; mem_write <= 1; mem_wdata <= 16'hbeef; lo_en <= 0;
        @(negedge clk); chk("bus write oe", 8'h00, low_pin_oe_n);
        @(posedge clk); mem_write <= 0; lo_en <= 8'hff;
        @(negedge clk); chk("bus read oe", 8'hff, low_pin_oe_n);
        chk("bus data out", 8'hef, low_pin_out);
        @(posedge clk); mem_access <= 0;
        @(negedge clk); chk("dir cleared by bus", 8'hff, low_pin_oe_n);
        $display("test bus takeover finished");
    endtask
    task t_high;
        wr(8'h14, 32'h0f, resp); wr(8'h10, 32'hf0, resp); hi_en <= 8'h0f; hi_ext <= 8'h05;
        @(negedge clk); chk("high oe", 8'h0f, high_pin_oe_n);
        rdreg(8'h04, rd); chk("high read", 32'h05, rd);
        @(posedge clk); mem_access <= 1; mem_write <= 1; hi_en <= 8'h00;
        @(negedge clk); chk("high bus oe", 8'h00, high_pin_oe_n);
        @(posedge clk); mem_access <= 0; mem_write <= 0; hi_en <= 8'hff;
        @(negedge clk); chk("high bus out", 8'h0e, high_pin_out);
        wr(8'h1c, 32'h1, resp); chk("unmapped resp", `RESP_SLVERR, resp);
        $display("test high port finished");
    endtask
    task t_boot;
        for (int i = 0; i < 4; i++) begin
            do_reset(i[1:0]);
            rdreg(8'h18, rd); chk("boot function", (i == 1) ? 32'hff : 32'h0, rd & 32'hff);
        end
        $display("test boot straps finished");
    endtask
    // =====================================
    // main sequence
    initial begin
        t_reset; t_low; t_mem; t_high; t_boot;
        results;
    end
    // whole run needs about a hundred cycles; 25000 means a hang
    initial begin
        #200000;
        mismatches++;
        results;
    end
endmodule
